// ===== inc/lprs_pkg.sv
// constants, register map and state type for the low-power and reset status block
// assumes a 32-bit apb slave with word-aligned registers, byte address = index * 4
package lprs_pkg;
	// apb address width, wide enough for index 16'hfe04 times four
	localparam int ADDR_W = 20;
	// register indices as printed, byte address is four times the index
	localparam logic [15:0] BRK_STAT_IDX = 16'hfe00;
	localparam logic [15:0] RST_STAT_IDX = 16'hfe01;
	localparam logic [15:0] BRK_CTRL_IDX = 16'hfe03;
	localparam logic [15:0] LP_CFG_IDX = 16'hfe04;
	// break_exit_status field
	localparam int BRK_EXIT_BIT = 1;
	// reset_source_status fields
	localparam int POR_BIT = 7;
	localparam int PIN_BIT = 6;
	localparam int WDOG_BIT = 5;
	localparam int BADOP_BIT = 4;
	localparam int BADFETCH_BIT = 3;
	localparam int MON_BIT = 2;
	localparam int LVR_BIT = 1;
	// break_flag_clear_control field
	localparam int BRK_CLR_EN_BIT = 7;
	// low-power config register: short recovery select in bit 0, state readback in bits 5:4
	localparam int SHORT_REC_BIT = 0;
	localparam int STATE_LSB = 4;
	// reset values
	localparam logic [7:0] RST_STAT_POR_VAL = 8'h80;
	localparam logic BRK_CLR_EN_RST = 1'b0;
	localparam logic SHORT_REC_RST = 1'b0;
	// stop recovery lengths in oscillator cycles
	localparam logic [12:0] REC_LONG_CYC = 13'h1000;
	localparam logic [12:0] REC_SHORT_CYC = 13'h0020;
	// erased reset vector byte
	localparam logic [7:0] VEC_ERASED = 8'hff;

	typedef enum logic [1:0]
	{
		LPRS_RUN = 2'b00,
		LPRS_WAIT = 2'b01,
		LPRS_STOP = 2'b10,
		LPRS_RECOVER = 2'b11
	} lprs_state_t;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction
endpackage

// ===== rtl/lprs_recovery_counter.sv
// stop recovery counter: held clear outside recovery, times the recovery interval
// assumes the caller holds target steady while counting
`timescale 1ns/1ns
module lprs_recovery_counter
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic clear_in,
	input wire logic [12:0] target_in,
	output logic [12:0] count_out,
	output logic done_out
);
	// count up while not cleared, flag the last cycle of the interval
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			count_out <= 13'h0000;
			done_out <= 1'b0;
		end
		else if (ce_in)
		begin
			if (clear_in)
			begin
				count_out <= 13'h0000;
				done_out <= 1'b0;
			end
			else
			begin
				count_out <= 13'(count_out + 13'h0001);
				done_out <= (count_out == 13'(target_in - 13'h0001));
			end
		end
	end
endmodule

// ===== rtl/lprs_top.sv
// low-power mode sequencer, stop recovery timing and break/reset status registers
// assumes apb from the cpu side, reset sources as one-cycle pulses, clk_in is the
// internal oscillator clock; rst_b_in is the power-on reset
//
// Overview of operation
// - entering stop clears the recovery counter and turns off system clocks
// - in stop the clock generator output is gated, halting cpu and peripherals
// - module interrupt ends stop; stacking starts only after recovery delay
// - reset or break interrupt also ends stop mode
// - recovery is 4096 cycles, or 32 when short recovery is selected
// - counter held clear from stop until recovery, then times recovery
// - low-power exit is reset pin or cpu interrupt or break interrupt
// - break-exit flag set when break ends wait or stop
// - writing zero or any reset clears the break-exit flag
// - break, reset and break-control registers sit at fe00, fe01, fe03
// - reading reset status clears all its flags
// - power-on reset sets power-on flag, clears all others
// - each reset source sets its own flag, earlier flags kept
// - pin, watchdog and low-voltage resets each set their own flag
// - bad opcode sets a flag; bad-address opcode fetch sets another
// - monitor-entry reset after power-on with erased vector sets a flag
// - break_clear_enable allows or blocks status clearing during break
// - two-step flag clears stay blocked in break, complete after it
// - wait stops cpu clocks, peripheral clocks keep running
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module lprs_top
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [19:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic wait_instr_in,
	input wire logic stop_instr_in,
	input wire logic cpu_irq_in,
	input wire logic break_irq_in,
	input wire logic break_state_in,
	input wire logic pin_reset_in,
	input wire logic watchdog_reset_in,
	input wire logic bad_opcode_in,
	input wire logic bad_fetch_in,
	input wire logic opcode_fetch_in,
	input wire logic monitor_reset_in,
	input wire logic [7:0] vector_lo_in,
	input wire logic [7:0] vector_hi_in,
	input wire logic int_pin_high_in,
	input wire logic low_voltage_in,
	output logic cpu_clk_en_out,
	output logic clk_gen_en_out,
	output logic stack_start_out,
	output logic flag_clear_allow_out,
	output logic break_exit_flag_out
);
	logic rst_meta_r;
	logic rst_sync_b;
	lprs_pkg::lprs_state_t st_r;
	lprs_pkg::lprs_state_t st_nxt;
	logic [7:0] rst_stat_r;
	logic brk_clr_en_r;
	logic short_rec_r;
	logic por_window_r;
	logic [12:0] rec_target_r;
	logic [12:0] rec_count;
	logic rec_done;
	logic [12:0] rec_len_r;
	logic low_power_exit;
	logic mon_ok;
	logic rst_evt;
	logic clr_allow;
	logic rd_done;
	logic wr_done;
	logic brk_set;
	logic stack_nxt;
	logic stat_rd_clr;
	logic brk_wr_clr;
	// true when the apb address selects the given register index
	function automatic logic reg_hit(input logic [19:0] a, input logic [15:0] idx);
		return a == lprs_pkg::reg_addr(idx);
	endfunction

	// sticky flag update, a set wins over a clear
	function automatic logic sticky(input logic q, input logic set, input logic clr);
		return set | (q & ~clr);
	endfunction

	// reset release through two flops
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_b <= rst_meta_r;
		end
	end

	// reset event qualification
	assign mon_ok = monitor_reset_in & por_window_r & int_pin_high_in &
		(vector_lo_in == lprs_pkg::VEC_ERASED) & (vector_hi_in == lprs_pkg::VEC_ERASED);
	assign rst_evt = pin_reset_in | watchdog_reset_in | bad_opcode_in | low_voltage_in |
		(bad_fetch_in & opcode_fetch_in) | mon_ok;
	assign low_power_exit = pin_reset_in | cpu_irq_in | break_irq_in;
	assign clr_allow = ~break_state_in | brk_clr_en_r;
	assign rd_done = psel_in & penable_in & pready_out & ~pwrite_in;
	assign wr_done = psel_in & penable_in & pready_out & pwrite_in;
	assign stat_rd_clr = rd_done & clr_allow & reg_hit(paddr_in, lprs_pkg::RST_STAT_IDX);
	assign brk_wr_clr = wr_done & clr_allow & reg_hit(paddr_in, lprs_pkg::BRK_STAT_IDX) &
		~pwdata_in[lprs_pkg::BRK_EXIT_BIT];
	assign brk_set = break_irq_in & ((st_r == lprs_pkg::LPRS_WAIT) |
		(st_r == lprs_pkg::LPRS_STOP));

	// low-power mode sequencing
	always_comb
	begin
		st_nxt = st_r;
		stack_nxt = 1'b0;
		case (st_r)
			lprs_pkg::LPRS_RUN:
			begin
				if (stop_instr_in)
					st_nxt = lprs_pkg::LPRS_STOP;
				else if (wait_instr_in)
					st_nxt = lprs_pkg::LPRS_WAIT;
			end
			lprs_pkg::LPRS_WAIT:
			begin
				if (low_power_exit | rst_evt)
				begin
					st_nxt = lprs_pkg::LPRS_RUN;
					stack_nxt = ~pin_reset_in & ~rst_evt;
				end
			end
			lprs_pkg::LPRS_STOP:
			begin
				if (pin_reset_in | rst_evt)
					st_nxt = lprs_pkg::LPRS_RUN;
				else if (cpu_irq_in | break_irq_in)
					st_nxt = lprs_pkg::LPRS_RECOVER;
			end
			lprs_pkg::LPRS_RECOVER:
			begin
				if (pin_reset_in | rst_evt)
					st_nxt = lprs_pkg::LPRS_RUN;
				else if (rec_done)
				begin
					st_nxt = lprs_pkg::LPRS_RUN;
					stack_nxt = 1'b1;
				end
			end
			default:
				st_nxt = lprs_pkg::LPRS_RUN;
		endcase
	end

	// state and clock gating outputs
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			st_r <= lprs_pkg::LPRS_RUN;
			cpu_clk_en_out <= 1'b1;
			clk_gen_en_out <= 1'b1;
			stack_start_out <= 1'b0;
		end
		else if (ce_in)
		begin
			st_r <= st_nxt;
			cpu_clk_en_out <= (st_nxt == lprs_pkg::LPRS_RUN);
			clk_gen_en_out <= (st_nxt == lprs_pkg::LPRS_RUN) |
				(st_nxt == lprs_pkg::LPRS_WAIT);
			stack_start_out <= stack_nxt;
		end
	end

	// recovery length latched as stop ends
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			rec_target_r <= lprs_pkg::REC_LONG_CYC;
		else if (ce_in && st_r == lprs_pkg::LPRS_STOP)
			rec_target_r <= short_rec_r ? lprs_pkg::REC_SHORT_CYC : lprs_pkg::REC_LONG_CYC;
	end

	// counter cleared in every state but recovery
	lprs_recovery_counter u_rec
	(
		.clk_in(clk_in),
		.rst_b_in(rst_sync_b),
		.ce_in(ce_in),
		.clear_in(st_r != lprs_pkg::LPRS_RECOVER),
		.target_in(rec_target_r),
		.count_out(rec_count),
		.done_out(rec_done)
	);

	// power-on window for monitor-entry reset
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			por_window_r <= 1'b1;
		else if (ce_in && rst_evt)
			por_window_r <= 1'b0;
	end

	// reset source flags, read clears unless protected
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			rst_stat_r <= lprs_pkg::RST_STAT_POR_VAL;
		else if (ce_in)
		begin
			rst_stat_r[lprs_pkg::POR_BIT] <= sticky(rst_stat_r[lprs_pkg::POR_BIT], 1'b0,
				stat_rd_clr);
			rst_stat_r[lprs_pkg::PIN_BIT] <= sticky(rst_stat_r[lprs_pkg::PIN_BIT], pin_reset_in,
				stat_rd_clr);
			rst_stat_r[lprs_pkg::WDOG_BIT] <= sticky(rst_stat_r[lprs_pkg::WDOG_BIT],
				watchdog_reset_in, stat_rd_clr);
			rst_stat_r[lprs_pkg::BADOP_BIT] <= sticky(rst_stat_r[lprs_pkg::BADOP_BIT],
				bad_opcode_in, stat_rd_clr);
			rst_stat_r[lprs_pkg::BADFETCH_BIT] <= sticky(rst_stat_r[lprs_pkg::BADFETCH_BIT],
				bad_fetch_in & opcode_fetch_in, stat_rd_clr);
			rst_stat_r[lprs_pkg::MON_BIT] <= sticky(rst_stat_r[lprs_pkg::MON_BIT], mon_ok,
				stat_rd_clr);
			rst_stat_r[lprs_pkg::LVR_BIT] <= sticky(rst_stat_r[lprs_pkg::LVR_BIT],
				low_voltage_in, stat_rd_clr);
			rst_stat_r[0] <= 1'b0;
		end
	end

	// break-exit flag: hardware set, zero write or reset clears
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			break_exit_flag_out <= 1'b0;
		else if (ce_in)
			break_exit_flag_out <= ~rst_evt &
				sticky(break_exit_flag_out, brk_set, brk_wr_clr);
	end

	// writable control bits
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			brk_clr_en_r <= lprs_pkg::BRK_CLR_EN_RST;
			short_rec_r <= lprs_pkg::SHORT_REC_RST;
		end
		else if (ce_in && wr_done)
		begin
			if (reg_hit(paddr_in, lprs_pkg::BRK_CTRL_IDX))
				brk_clr_en_r <= pwdata_in[lprs_pkg::BRK_CLR_EN_BIT];
			if (reg_hit(paddr_in, lprs_pkg::LP_CFG_IDX))
				short_rec_r <= pwdata_in[lprs_pkg::SHORT_REC_BIT];
		end
	end

	// clear permission for two-step flags in other modules
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			flag_clear_allow_out <= 1'b1;
		else if (ce_in)
			flag_clear_allow_out <= clr_allow;
	end

	// apb slave: answer in the first access cycle, read data captured in setup
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
		end
		else if (ce_in)
		begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in &
				~(reg_hit(paddr_in, lprs_pkg::BRK_STAT_IDX) |
				reg_hit(paddr_in, lprs_pkg::RST_STAT_IDX) |
				reg_hit(paddr_in, lprs_pkg::BRK_CTRL_IDX) |
				reg_hit(paddr_in, lprs_pkg::LP_CFG_IDX));
			prdata_out <= 32'h00000000;
			if (psel_in && !penable_in && !pwrite_in)
			begin
				if (reg_hit(paddr_in, lprs_pkg::BRK_STAT_IDX))
					prdata_out[lprs_pkg::BRK_EXIT_BIT] <= break_exit_flag_out;
				if (reg_hit(paddr_in, lprs_pkg::RST_STAT_IDX))
					prdata_out[7:0] <= rst_stat_r;
				if (reg_hit(paddr_in, lprs_pkg::BRK_CTRL_IDX))
					prdata_out[lprs_pkg::BRK_CLR_EN_BIT] <= brk_clr_en_r;
				if (reg_hit(paddr_in, lprs_pkg::LP_CFG_IDX))
				begin
					prdata_out[lprs_pkg::SHORT_REC_BIT] <= short_rec_r;
					prdata_out[lprs_pkg::STATE_LSB +: 2] <= st_r;
				end
			end
		end
	end

	// helper: cycles spent in recovery
	always_ff @(posedge clk_in or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			rec_len_r <= 13'h0000;
		else if (ce_in)
			rec_len_r <= (st_r == lprs_pkg::LPRS_RECOVER) ? 13'(rec_len_r + 13'h0001) : 13'h0000;
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_sync_b);

	// checks on the sequencer and status registers
	AST_STOP_CLOCKS_OFF: assert property (
		ce_in && st_nxt == lprs_pkg::LPRS_STOP |=> !clk_gen_en_out && !cpu_clk_en_out)
		else $error("clocks running in stop");
	AST_STOP_COUNT_CLEAR: assert property (
		st_r == lprs_pkg::LPRS_STOP && $past(st_r) == lprs_pkg::LPRS_STOP |-> rec_count == 13'h0000)
		else $error("recovery counter not held in stop");
	AST_RECOVERY_LENGTH: assert property (
		ce_in && st_r == lprs_pkg::LPRS_RECOVER && rec_done && !rst_evt && !pin_reset_in
		|-> rec_len_r == rec_target_r ##1 stack_start_out)
		else $error("recovery length wrong");
	AST_STACK_CAUSE: assert property (
		stack_start_out |-> $past(st_r) != lprs_pkg::LPRS_STOP && $past(st_r) != lprs_pkg::LPRS_RUN)
		else $error("stacking without recovery or wait exit");
	AST_WAIT_EXIT: assert property (
		ce_in && st_r == lprs_pkg::LPRS_WAIT && low_power_exit |=> st_r == lprs_pkg::LPRS_RUN)
		else $error("wait not exited");
	AST_WAIT_CLOCKS: assert property (
		st_r == lprs_pkg::LPRS_WAIT |-> !cpu_clk_en_out && clk_gen_en_out)
		else $error("wait clock gating wrong");
	AST_BREAK_FLAG_SET: assert property (
		ce_in && brk_set && !rst_evt |=> break_exit_flag_out)
		else $error("break exit flag not set");
	AST_BREAK_FLAG_RESET: assert property (
		ce_in && rst_evt |=> !break_exit_flag_out)
		else $error("break exit flag survived reset");
	AST_WRITE_ONE_IGNORED: assert property (
		ce_in && wr_done && pwdata_in[lprs_pkg::BRK_EXIT_BIT] && !break_exit_flag_out && !brk_set
		|=> !break_exit_flag_out)
		else $error("write one set break exit flag");
	AST_READ_CLEARS: assert property (
		ce_in && rd_done && clr_allow && reg_hit(paddr_in, lprs_pkg::RST_STAT_IDX) && !rst_evt
		|=> rst_stat_r == 8'h00)
		else $error("reset status not cleared by read");
	AST_READ_PROTECTED: assert property (
		ce_in && !clr_allow && !rst_evt |=> rst_stat_r == $past(rst_stat_r))
		else $error("reset status cleared during protected break");
	AST_WDOG_FLAG: assert property (
		ce_in && watchdog_reset_in |=> rst_stat_r[lprs_pkg::WDOG_BIT])
		else $error("watchdog flag not set");

	COV_STOP_RECOVER: cover property (st_r == lprs_pkg::LPRS_STOP ##1 st_r == lprs_pkg::LPRS_RECOVER);
	COV_RECOVER_DONE: cover property (st_r == lprs_pkg::LPRS_RECOVER ##1 stack_start_out);
	COV_WAIT_BREAK: cover property (brk_set && st_r == lprs_pkg::LPRS_WAIT);
	COV_PROTECTED_READ: cover property (rd_done && !clr_allow);
endmodule

// ===== testbench/lprs_cpu_model.sv
// cpu and clock-generator side: issues wait or stop, then a wake request
// assumes go_in is a one-cycle pulse from the bench on the oscillator clock
`timescale 1ns/1ns
module lprs_cpu_model
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic stop_sel_in,
	input wire logic [1:0] wake_in,
	input wire logic [12:0] delay_in,
	input wire logic stack_in,
	output logic wait_instr_out,
	output logic stop_instr_out,
	output logic cpu_irq_out,
	output logic break_irq_out
);
	logic [12:0] cnt_r;
	logic armed_r;
	// quiet at time zero
	initial
	begin
		wait_instr_out = 1'b0;
		stop_instr_out = 1'b0;
		cpu_irq_out = 1'b0;
		break_irq_out = 1'b0;
		armed_r = 1'b0;
		cnt_r = 13'h0000;
	end
	// instruction pulse on go, wake request after the delay
	always @(posedge clk_in)
	begin
		wait_instr_out <= go_in && !stop_sel_in;
		stop_instr_out <= go_in && stop_sel_in;
		if (go_in)
		begin
			armed_r <= (wake_in != 2'b00);
			cnt_r <= delay_in;
		end
		else if (armed_r && cnt_r != 13'h0000)
			cnt_r <= cnt_r - 13'h0001;
		else if (armed_r)
		begin
			cpu_irq_out <= wake_in[0];
			break_irq_out <= wake_in[1];
			armed_r <= 1'b0;
		end
		// request withdrawn once stacking begins
		if (stack_in)
		begin
			cpu_irq_out <= 1'b0;
			break_irq_out <= 1'b0;
		end
	end
endmodule

// ===== testbench/tb_top.sv
// bench for the low-power sequencer and break/reset status registers
// assumes the cpu model file is compiled first; apb answers without waits
`timescale 1ns/1ns
module tb_top;
	logic clk, rst_b, psel, penable, pwrite, go, stop_sel, brk_state, opf, mon, err;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, cpu_en, gen_en, stack, allow, bflag;
	logic [1:0] wake;
	logic [12:0] dly;
	logic [4:0] src;
	logic [15:0] vec;
	logic pin1;
	wire wait_i, stop_i, irq, brk;
	int bad_count, compares, cycles;
	lprs_top dut (.clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.wait_instr_in(wait_i), .stop_instr_in(stop_i), .cpu_irq_in(irq),
		.break_irq_in(brk), .break_state_in(brk_state), .pin_reset_in(src[0]),
		.watchdog_reset_in(src[1]), .bad_opcode_in(src[2]), .bad_fetch_in(src[4]),
		.opcode_fetch_in(opf), .monitor_reset_in(mon),
		.vector_lo_in(vec[7:0]), .vector_hi_in(vec[15:8]),
		.int_pin_high_in(pin1), .low_voltage_in(src[3]), .cpu_clk_en_out(cpu_en),
		.clk_gen_en_out(gen_en), .stack_start_out(stack), .flag_clear_allow_out(allow),
		.break_exit_flag_out(bflag));
	lprs_cpu_model cpu (.clk_in(clk), .go_in(go), .stop_sel_in(stop_sel), .wake_in(wake),
		.delay_in(dly), .stack_in(stack), .wait_instr_out(wait_i), .stop_instr_out(stop_i),
		.cpu_irq_out(irq), .break_irq_out(brk));
	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles >= 20000)
		begin
			bad_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= lprs_pkg::ADDR_W'({idx, 2'b00});
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one-cycle pulse on a reset source line
	task automatic pulse(input int i);
		@(posedge clk);
		src <= 5'h01 << i;
		@(posedge clk);
		src <= 5'h00;
	endtask
	// enter wait or stop, check clocks, return cycles from wake seen to stacking
	task automatic run_lp(input logic s, input logic [1:0] wk, output int n);
		@(posedge clk);
		go <= 1'b1;
		stop_sel <= s;
		wake <= wk;
		dly <= 13'h0006;
		@(posedge clk);
		go <= 1'b0;
		cyc(3);
		chk_val(cpu_en, 32'h0);
		chk_val(gen_en, {31'h0, !s});
		n = 0;
		while (irq !== 1'b1 && brk !== 1'b1 && n < 100 && wk != 2'b00)
			cyc(1);
		while (stack !== 1'b1 && n < 6000 && wk != 2'b00)
		begin
			cyc(1);
			n++;
		end
	endtask
	// one monitor-entry pulse with given vector bytes and interrupt pin level
	task automatic mon_pulse(input logic [15:0] v, input logic p);
		@(posedge clk);
		mon <= 1'b1;
		vec <= v;
		pin1 <= p;
		@(posedge clk);
		mon <= 1'b0;
		vec <= 16'hffff;
		pin1 <= 1'b1;
	endtask
	task automatic t_monitor();
		mon_pulse(16'hff00, 1'b1);
		mon_pulse(16'h00ff, 1'b1);
		mon_pulse(16'hffff, 1'b0);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h80);
		mon_pulse(16'hffff, 1'b1);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h04);
		mon_pulse(16'hffff, 1'b1);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h00);
		apb(1'b0, 16'hfe02, 8'h00);
		chk_val({rd[30:0], err}, 32'h1);
		apb(1'b0, lprs_pkg::BRK_CTRL_IDX, 8'h00);
		chk_val(rd, 32'h00);
	endtask
	task automatic t_sources();
		for (int i = 0; i < 4; i++)
			pulse(i);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h72);
		pulse(4);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h00);
		opf <= 1'b1;
		pulse(4);
		opf <= 1'b0;
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h08);
	endtask
	task automatic t_wait_break();
		int n;
		run_lp(1'b0, 2'b10, n);
		cyc(2);
		chk_val(bflag, 32'h1);
		apb(1'b1, lprs_pkg::BRK_STAT_IDX, 8'h02);
		apb(1'b0, lprs_pkg::BRK_STAT_IDX, 8'h00);
		chk_val(rd, 32'h02);
		apb(1'b1, lprs_pkg::BRK_STAT_IDX, 8'h00);
		apb(1'b0, lprs_pkg::BRK_STAT_IDX, 8'h00);
		chk_val(rd, 32'h00);
		apb(1'b1, lprs_pkg::BRK_STAT_IDX, 8'h02);
		apb(1'b0, lprs_pkg::BRK_STAT_IDX, 8'h00);
		chk_val(rd, 32'h00);
	endtask
	task automatic t_stop(input logic sh, input int exp);
		int n;
		apb(1'b1, lprs_pkg::LP_CFG_IDX, {7'h00, sh});
		run_lp(1'b1, 2'b01, n);
		chk_cnt(n, exp);
		cyc(1);
		chk_val({cpu_en, gen_en}, 32'h3);
		apb(1'b0, lprs_pkg::LP_CFG_IDX, 8'h00);
		chk_val(rd, {31'h0, sh});
	endtask
	task automatic t_stop_exits();
		int n;
		run_lp(1'b1, 2'b10, n);
		cyc(2);
		chk_val(bflag, 32'h1);
		run_lp(1'b1, 2'b00, n);
		apb(1'b0, lprs_pkg::LP_CFG_IDX, 8'h00);
		chk_val(rd, 32'h20);
		pulse(0);
		cyc(1);
		chk_val({cpu_en, gen_en, bflag}, 32'h6);
		for (int i = 0; i < 40; i++)
		begin
			cyc(1);
			n += stack;
		end
		chk_cnt(n, 0);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h40);
	endtask
	task automatic t_clr_enable();
		int n;
		run_lp(1'b0, 2'b10, n);
		brk_state <= 1'b1;
		cyc(3);
		chk_val(allow, 32'h0);
		apb(1'b1, lprs_pkg::BRK_STAT_IDX, 8'h00);
		cyc(1);
		chk_val(bflag, 32'h1);
		apb(1'b1, lprs_pkg::BRK_CTRL_IDX, 8'h80);
		apb(1'b0, lprs_pkg::BRK_CTRL_IDX, 8'h00);
		chk_val(rd, 32'h80);
		cyc(2);
		chk_val(allow, 32'h1);
		apb(1'b1, lprs_pkg::BRK_STAT_IDX, 8'h00);
		cyc(1);
		chk_val(bflag, 32'h0);
		apb(1'b1, lprs_pkg::BRK_CTRL_IDX, 8'h00);
		pulse(1);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h20);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h20);
		brk_state <= 1'b0;
		cyc(2);
		chk_val(allow, 32'h1);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h20);
		apb(1'b0, lprs_pkg::RST_STAT_IDX, 8'h00);
		chk_val(rd, 32'h00);
	endtask
	// main sequence
	initial
	begin
		{rst_b, psel, penable, pwrite, go, stop_sel, brk_state, opf, mon} = 9'h000;
		paddr = 20'h00000;
		pwdata = 32'h00000000;
		wake = 2'b00;
		dly = 13'h0000;
		src = 5'h00;
		vec = 16'hffff;
		pin1 = 1'b1;
		bad_count = 0;
		compares = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		cyc(4);
		t_monitor();
		t_sources();
		t_wait_break();
		t_stop(1'b1, 34);
		t_stop(1'b0, 4098);
		t_stop_exits();
		t_clr_enable();
		cyc(5);
		conclude();
	end
endmodule
